//--- bench/cvr_analog_model.sv
// Behavioural model of the three analog comparators and the reference ladder
module cvr_analog_model #(
   parameter logic [3:0] HALF_BG   = 4'h8,
   parameter int         SETTLE_NS = 8
) (
   input  wire logic [2:0]           i_noninv_ref_select,
   input  wire logic [5:0]           i_inverting_channel_select,
   input  wire logic                 i_reference_power_enable,
   input  wire logic [3:0]           i_reference_level_value,
   input  wire logic [2:0][3:0]      i_pin_a,
   input  wire logic [2:0][2:0][3:0] i_pin_bcd,
   output logic      [2:0]           o_cmp_raw
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Reference ladder and input muxes
   // ----------------------------------------------------------------
   logic [3:0] ref_level;
   logic [3:0] vp;
   logic [3:0] vm;

   initial ref_level = 4'h0;

   // Tap settles late, so a fast compare right after a change is stale
   always @(i_reference_level_value or i_reference_power_enable) begin
      ref_level <= #(SETTLE_NS) (i_reference_power_enable ? i_reference_level_value : 4'h0);
   end

   // Equal inputs compare low; voltages are coarse 4-bit codes
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         vp = i_noninv_ref_select[c] ? ref_level : i_pin_a[c];
         vm = (i_inverting_channel_select[2*c+:2] == 2'h3) ? HALF_BG
              : i_pin_bcd[c][i_inverting_channel_select[2*c+:2]];
         o_cmp_raw[c] = vp > vm;
      end
   end
endmodule : cvr_analog_model

//--- bench/cvr_regs_tb.sv
// Self-checking testbench of the comparator register bank
module cvr_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [3:0] HALF_BG = 4'h8;

   logic                 i_clk, i_reset, i_wr, i_rd, i_idle, rd_seen;
   logic [3:0]           i_addr;
   logic [15:0]          i_wdata, d;
   logic [2:0]           cmp_raw, nref, pin_oe, pin_out, trig, en;
   logic [5:0]           chan;
   logic                 pwr, ref_oe, rng, src, irq;
   logic [3:0]           lvl;
   logic [15:0]          rdata, ref_sh;
   logic [15:0]          sh [3];
   logic [2:0][3:0]      pin_a;
   logic [2:0][2:0][3:0] pin_bcd;
   logic [15:0]          exp_q [$];
   int                   mismatches, num_checks, trig_cnt, seed;

   cvr_regs i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_idle(i_idle), .i_cmp_raw(cmp_raw), .o_rdata(rdata),
      .o_noninv_ref_select(nref), .o_inverting_channel_select(chan), .o_cmp_enable(en),
      .o_cmp_pin_oe(pin_oe), .o_cmp_pin_out(pin_out), .o_trigger(trig),
      .o_reference_power_enable(pwr), .o_reference_pin_output_enable(ref_oe),
      .o_reference_range_select(rng), .o_reference_source_select(src),
      .o_reference_level_value(lvl), .o_irq(irq));

   cvr_analog_model #(.HALF_BG(HALF_BG)) i_model (.i_noninv_ref_select(nref),
      .i_inverting_channel_select(chan), .i_reference_power_enable(pwr),
      .i_reference_level_value(lvl), .i_pin_a(pin_a), .i_pin_bcd(pin_bcd), .o_cmp_raw(cmp_raw));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : settle

   task automatic bus_write(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask : bus_write

   // Expected word goes on the queue; the monitor compares it later
   task automatic bus_read(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_clk);
      exp_q.push_back(exp);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
   endtask : bus_read

   // Dip the reference below half bandgap and lift it above, then let it settle
   task automatic toggle;
      bus_write(4'h4, 16'h0080);
      settle(8);
      bus_write(4'h4, 16'h008F);
      settle(8);
   endtask : toggle

   // Polarity-adjusted result worked out from the pin codes and shadows
   function automatic logic exp_out(input int c);
      logic [3:0] p;
      logic [3:0] m;
      p = sh[c][4] ? (ref_sh[7] ? ref_sh[3:0] : 4'h0) : pin_a[c];
      m = (sh[c][1:0] == 2'h3) ? HALF_BG : pin_bcd[c][sh[c][1:0]];
      return sh[c][15] & ((p > m) ^ sh[c][13]);
   endfunction : exp_out

   // Read data stand one cycle after the strobe; comparator one trigger pulses counted
   always @(posedge i_clk) begin
      rd_seen <= i_rd;
      if (trig[0] === 1'b1) trig_cnt <= trig_cnt + 1;
      if (rd_seen) check(rdata, exp_q.pop_front());
   end

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // Watchdog well beyond the expected run length
   initial begin
      #80000;
      mismatches++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h8683;
      {i_reset, i_wr, i_rd, i_idle, i_addr, i_wdata} = {1'b1, 3'b000, 4'h0, 16'h0000};
      {pin_a, pin_bcd, mismatches, num_checks, trig_cnt} = '0;
      sh = '{default: 16'h0000};
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
      // Reset values everywhere, unmapped indices read zero
      for (int a = 0; a < 16; a++) bus_read(a[3:0], 16'h0000);
      // Reference control fields straight through to the ladder
      repeat (8) begin
         d = 16'($random(seed));
         bus_write(4'h4, d);
         settle(2);
         check({8'h00, pwr, ref_oe, rng, src, lvl}, {8'h00, d[7:0]});
         bus_read(4'h4, {8'h00, d[7:0]});
      end
      // Every channel code and reference choice on every comparator
      for (int c = 0; c < 3; c++) begin
         for (int k = 0; k < 8; k++) begin
            pin_a[c] = 4'($random(seed));
            pin_bcd[c] = 12'($random(seed));
            ref_sh = {12'h080, 4'($random(seed))};
            sh[c] = (16'($random(seed)) & 16'h7F2C) | 16'h8000 | {11'h0, k[2], 2'h0, k[1:0]};
            bus_write(4'h4, ref_sh);
            bus_write(c[3:0], sh[c]);
            settle(8);
            check({en[c], nref[c], chan[2*c+:2], pin_oe[c], pin_out[c]},
                  {sh[c][15], sh[c][4], sh[c][1:0], sh[c][14], exp_out(c)});
            bus_read(c[3:0], (sh[c] & 16'hE0D3) | {7'h00, exp_out(c), 8'h00});
            bus_read(4'h3, {13'h0000, exp_out(2), exp_out(1), exp_out(0)});
         end
         bus_write(c[3:0], 16'h0000);
         // Disabled comparator reads zero in the later status mirrors
         sh[c] = 16'h0000;
      end
      // Rising event on comparator one, interrupt unmasked
      bus_write(4'h6, 16'h0001);
      bus_write(4'h0, 16'h8053);
      toggle();
      check(trig_cnt[15:0], 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      bus_read(4'h0, 16'h8353);
      bus_read(4'h3, 16'h0101);
      bus_read(4'h5, 16'h0001);
      // Flag still set, so a second rise is swallowed
      toggle();
      check(trig_cnt[15:0], 16'h0001);
      // Masked event, then unmask and clear
      bus_write(4'h6, 16'h0000);
      bus_write(4'h5, 16'h0001);
      bus_write(4'h0, 16'h8053);
      toggle();
      check(trig_cnt[15:0], 16'h0002);
      check({15'h0000, irq}, 16'h0000);
      bus_write(4'h6, 16'h0001);
      settle(3);
      check({15'h0000, irq}, 16'h0001);
      bus_write(4'h5, 16'h0001);
      settle(3);
      check({15'h0000, irq}, 16'h0000);
      // Idle with stop set: event works, interrupt held off
      bus_write(4'h0, 16'h8053);
      bus_write(4'h3, 16'hFFFF);
      @(posedge i_clk);
      i_idle <= 1'b1;
      bus_read(4'h3, 16'h8001);
      toggle();
      check(trig_cnt[15:0], 16'h0003);
      bus_read(4'h5, 16'h0000);
      bus_read(4'h3, 16'h8101);
      check({15'h0000, irq}, 16'h0000);
      // Idle with stop clear: interrupts carry on
      bus_write(4'h3, 16'h0000);
      bus_write(4'h0, 16'h8053);
      toggle();
      bus_read(4'h5, 16'h0001);
      settle(3);
      final_report();
   end
endmodule : cvr_regs_tb

//--- hdl/cvr_event.sv
// Per-comparator polarity, edge detection and sticky event flag
module cvr_event (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic       i_raw,
   input  wire logic       i_enable,
   input  wire logic       i_invert,
   input  wire logic [1:0] i_evpol,
   input  wire logic       i_clear,
   output logic            o_result,
   output logic            o_event,
   output logic            o_pulse
);

   logic prev;
   logic next_result;
   logic trig;

   // Result with polarity applied; disabled comparator reads zero
   assign next_result = i_enable & (i_raw ^ i_invert);

   // Edge selection per event polarity code
   always_comb begin
      unique case (cvr_pkg::cvr_evpol_t'(i_evpol))
         cvr_pkg::CVR_EV_OFF:  trig = 1'b0;
         cvr_pkg::CVR_EV_RISE: trig = next_result & ~prev;
         cvr_pkg::CVR_EV_FALL: trig = ~next_result & prev;
         cvr_pkg::CVR_EV_ANY:  trig = next_result ^ prev;
      endcase
   end

   // ---------------------------------------------
   // Flag: set wins over a clear in the same cycle
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         prev     <= 1'b0;
         o_result <= 1'b0;
         o_event  <= 1'b0;
         o_pulse  <= 1'b0;
      end else begin
         prev     <= next_result;
         o_result <= next_result;
         o_pulse  <= trig & ~o_event;
         if (trig & ~o_event) begin
            o_event <= 1'b1;
         end else if (i_clear) begin
            o_event <= 1'b0;
         end
      end
   end

endmodule : cvr_event

//--- hdl/cvr_pkg.sv
// Types shared by the comparator register bank
package cvr_pkg;

   // Inverting input selection codes
   typedef enum logic [1:0] {
      CVR_INV_PIN_B   = 2'h0,
      CVR_INV_PIN_C   = 2'h1,
      CVR_INV_PIN_D   = 2'h2,
      CVR_INV_HALF_BG = 2'h3
   } cvr_inv_sel_t;

   // Event polarity codes
   typedef enum logic [1:0] {
      CVR_EV_OFF  = 2'h0,
      CVR_EV_RISE = 2'h1,
      CVR_EV_FALL = 2'h2,
      CVR_EV_ANY  = 2'h3
   } cvr_evpol_t;

endpackage : cvr_pkg

//--- hdl/cvr_regs.sv
// Register bank for the triple comparator and its voltage reference
// Operation
// - Reference bit picks internal reference, else A
// - Channel code picks B, C, D or half bandgap
// - Idle-stop bit suppresses interrupts while idle
// - Status bits 10..8 mirror event flags
// - Status bits 2..0 mirror comparator outputs
// - Enable bit powers the reference
// - Output-enable bit drives reference pin
// - Range bit selects step size and offset
// - Source bit selects external pins or rails
// - Four-bit level passes to ladder tap
// - Event flag sticky; blocks further triggers
// - Output bit follows polarity-adjusted compare
`include "cvr_regs_map.svh"

module cvr_regs #(
   parameter int NCMP = 3
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic [3:0]   i_addr,
   input  wire logic [15:0]  i_wdata,
   input  wire logic         i_wr,
   input  wire logic         i_rd,
   input  wire logic         i_idle,
   input  wire logic [2:0]   i_cmp_raw,
   output logic      [15:0]  o_rdata,
   output logic      [2:0]   o_noninv_ref_select,
   output logic      [5:0]   o_inverting_channel_select,
   output logic      [2:0]   o_cmp_enable,
   output logic      [2:0]   o_cmp_pin_oe,
   output logic      [2:0]   o_cmp_pin_out,
   output logic      [2:0]   o_trigger,
   output logic              o_reference_power_enable,
   output logic              o_reference_pin_output_enable,
   output logic              o_reference_range_select,
   output logic              o_reference_source_select,
   output logic      [3:0]   o_reference_level_value,
   output logic              o_irq
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [15:0]     ctrl [NCMP];
   logic            idle_interrupt_stop;
   logic [7:0]      ref_ctrl;
   logic [NCMP-1:0] irq_status;
   logic [NCMP-1:0] irq_mask;
   logic [NCMP-1:0] comparator_event_flag;
   logic [NCMP-1:0] comparator_result_bit;
   logic [NCMP-1:0] evt_pulse;
   logic [NCMP-1:0] evt_clear;
   logic [NCMP-1:0] raw_sync;
   logic [15:0]     status_word;
   logic [15:0]     next_rdata;

   // ----------------------------------------------------------------
   // Per-comparator logic
   // ----------------------------------------------------------------
   for (genvar c = 0; c < NCMP; c++) begin : g_cmp
      // Software clears the flag by writing zero to the event bit
      assign evt_clear[c] = i_wr && i_addr == 4'(c)
                            && !i_wdata[`CVR_CC_EVENT];

      cvr_sync u_sync (
         .i_clk   (i_clk),
         .i_reset (i_reset),
         .i_async (i_cmp_raw[c]),
         .o_sync  (raw_sync[c])
      );

      cvr_event u_evt (
         .i_clk    (i_clk),
         .i_reset  (i_reset),
         .i_raw    (raw_sync[c]),
         .i_enable (ctrl[c][`CVR_CC_ENABLE]),
         .i_invert (ctrl[c][`CVR_CC_POLARITY]),
         .i_evpol  (ctrl[c][`CVR_CC_EVPOL_HI:`CVR_CC_EVPOL_LO]),
         .i_clear  (evt_clear[c]),
         .o_result (comparator_result_bit[c]),
         .o_event  (comparator_event_flag[c]),
         .o_pulse  (evt_pulse[c])
      );

      // Control register: only writable fields stored
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            ctrl[c] <= `CVR_RST_CTRL;
         end else if (i_wr && i_addr == 4'(c)) begin
            ctrl[c] <= i_wdata & `CVR_CC_WMASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Module status and reference control
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         idle_interrupt_stop <= 1'b0;
      end else if (i_wr && i_addr == `CVR_OFS_STATUS) begin
         idle_interrupt_stop <= i_wdata[`CVR_ST_IDLE_STOP];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ref_ctrl <= `CVR_RST_REF;
      end else if (i_wr && i_addr == `CVR_OFS_REF_CTRL) begin
         ref_ctrl <= i_wdata[7:0];
      end
   end

   // Mirrors are live copies, never written
   always_comb begin
      status_word = 16'h0000;
      status_word[`CVR_ST_IDLE_STOP] = idle_interrupt_stop;
      status_word[`CVR_ST_EVT_LO +: 3] = comparator_event_flag;
      status_word[`CVR_ST_OUT_LO +: 3] = comparator_result_bit;
   end

   // ----------------------------------------------------------------
   // Interrupts: sticky status, write one to clear, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_status <= '0;
      end else begin
         for (int c = 0; c < NCMP; c++) begin
            if (evt_pulse[c] && !(i_idle && idle_interrupt_stop)) begin
               irq_status[c] <= 1'b1;
            end else if (i_wr && i_addr == `CVR_OFS_IRQ_STATUS && i_wdata[c]) begin
               irq_status[c] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_mask <= '0;
      end else if (i_wr && i_addr == `CVR_OFS_IRQ_MASK) begin
         irq_mask <= i_wdata[NCMP-1:0];
      end
   end

   // Registered so the line is glitch free
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // Read port: data valid the cycle after the strobe only
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = 16'h0000;
      unique case (i_addr)
         `CVR_OFS_CMP1_CTRL, `CVR_OFS_CMP2_CTRL, `CVR_OFS_CMP3_CTRL: begin
            next_rdata = ctrl[i_addr[1:0]];
            next_rdata[`CVR_CC_EVENT]  = comparator_event_flag[i_addr[1:0]];
            next_rdata[`CVR_CC_RESULT] = comparator_result_bit[i_addr[1:0]];
         end
         `CVR_OFS_STATUS:     next_rdata = status_word;
         `CVR_OFS_REF_CTRL:   next_rdata = {8'h00, ref_ctrl};
         `CVR_OFS_IRQ_STATUS: next_rdata = {13'h0000, irq_status};
         `CVR_OFS_IRQ_MASK:   next_rdata = {13'h0000, irq_mask};
         default:             next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Analog control outputs, registered
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_noninv_ref_select        <= '0;
         o_inverting_channel_select <= '0;
         o_cmp_enable               <= '0;
         o_cmp_pin_oe               <= '0;
         o_cmp_pin_out              <= '0;
         o_trigger                  <= '0;
      end else begin
         for (int c = 0; c < NCMP; c++) begin
            o_noninv_ref_select[c] <= ctrl[c][`CVR_CC_REFSEL];
            o_inverting_channel_select[2*c +: 2] <=
               ctrl[c][`CVR_CC_CHAN_HI:`CVR_CC_CHAN_LO];
            o_cmp_enable[c]  <= ctrl[c][`CVR_CC_ENABLE];
            o_cmp_pin_oe[c]  <= ctrl[c][`CVR_CC_PIN_OE];
         end
         o_cmp_pin_out <= comparator_result_bit;
         o_trigger     <= evt_pulse;
      end
   end

   // Reference ladder controls; settling is software's concern
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_reference_power_enable      <= 1'b0;
         o_reference_pin_output_enable <= 1'b0;
         o_reference_range_select      <= 1'b0;
         o_reference_source_select     <= 1'b0;
         o_reference_level_value       <= 4'h0;
      end else begin
         o_reference_power_enable      <= ref_ctrl[`CVR_RC_POWER];
         o_reference_pin_output_enable <= ref_ctrl[`CVR_RC_PIN_OE];
         o_reference_range_select      <= ref_ctrl[`CVR_RC_RANGE];
         o_reference_source_select     <= ref_ctrl[`CVR_RC_SOURCE];
         o_reference_level_value       <=
            ref_ctrl[`CVR_RC_LEVEL_HI:`CVR_RC_LEVEL_LO];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   ref_level_follow_a: assert property (
      i_wr && i_addr == `CVR_OFS_REF_CTRL ##2 1
      |-> o_reference_level_value == $past(i_wdata[3:0], 2))
      else $error("reference level not passed to ladder");

   ref_power_follow_a: assert property (
      i_wr && i_addr == `CVR_OFS_REF_CTRL ##2 1
      |-> o_reference_power_enable == $past(i_wdata[7], 2))
      else $error("reference power bit not applied");

   ref_pin_follow_a: assert property (
      ##2 o_reference_pin_output_enable == $past(ref_ctrl[6], 1))
      else $error("reference pin enable wrong");

   range_source_a: assert property (
      ##1 o_reference_range_select == $past(ref_ctrl[5])
      && o_reference_source_select == $past(ref_ctrl[4]))
      else $error("range or source select wrong");

   chan_select_a: assert property (
      ##1 o_inverting_channel_select[1:0] == $past(ctrl[0][1:0])
      && o_noninv_ref_select[0] == $past(ctrl[0][4]))
      else $error("input selection not routed");

   event_sticky_a: assert property (
      comparator_event_flag[0] && !evt_clear[0] |=> comparator_event_flag[0])
      else $error("event flag lost without clear");

   no_retrigger_a: assert property (
      comparator_event_flag[1] |=> !evt_pulse[1])
      else $error("trigger while event flag set");

   idle_stop_a: assert property (
      i_idle && idle_interrupt_stop && irq_status == '0 ##1 i_idle
      && idle_interrupt_stop |-> irq_status == '0)
      else $error("interrupt raised during idle stop");

   mirror_read_a: assert property (
      i_rd && i_addr == `CVR_OFS_STATUS
      |=> o_rdata[10:8] == $past(comparator_event_flag)
      && o_rdata[2:0] == $past(comparator_result_bit))
      else $error("status mirror mismatch");

   unused_zero_a: assert property (
      i_rd && i_addr == `CVR_OFS_REF_CTRL |=> o_rdata[15:8] == 8'h00)
      else $error("unimplemented bits read nonzero");

   result_polarity_a: assert property (
      ##1 comparator_result_bit[2] ==
      ($past(ctrl[2][15]) & ($past(raw_sync[2]) ^ $past(ctrl[2][13]))))
      else $error("result polarity wrong");

   event_seen_c:   cover property (evt_pulse[0] ##1 comparator_event_flag[0]);
   irq_raised_c:   cover property (!o_irq ##1 o_irq);
   idle_block_c:   cover property (i_idle && idle_interrupt_stop && |evt_pulse);
   ref_on_c:       cover property (o_reference_power_enable && o_reference_pin_output_enable);

endmodule : cvr_regs

//--- hdl/cvr_regs_map.svh
// Register offsets, field positions and reset values of the comparator register bank
`ifndef CVR_REGS_MAP_SVH
`define CVR_REGS_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define CVR_OFS_CMP1_CTRL   4'h0
`define CVR_OFS_CMP2_CTRL   4'h1
`define CVR_OFS_CMP3_CTRL   4'h2
`define CVR_OFS_STATUS      4'h3
`define CVR_OFS_REF_CTRL    4'h4
`define CVR_OFS_IRQ_STATUS  4'h5
`define CVR_OFS_IRQ_MASK    4'h6

// ----------------------------------------------------------------
// Comparator control fields
// ----------------------------------------------------------------
`define CVR_CC_ENABLE       15
`define CVR_CC_PIN_OE       14
`define CVR_CC_POLARITY     13
`define CVR_CC_EVENT        9
`define CVR_CC_RESULT       8
`define CVR_CC_EVPOL_HI     7
`define CVR_CC_EVPOL_LO     6
`define CVR_CC_REFSEL       4
`define CVR_CC_CHAN_HI      1
`define CVR_CC_CHAN_LO      0
`define CVR_CC_WMASK        16'hE0D3

// ----------------------------------------------------------------
// Status and reference fields
// ----------------------------------------------------------------
`define CVR_ST_IDLE_STOP    15
`define CVR_ST_EVT_LO       8
`define CVR_ST_OUT_LO       0
`define CVR_RC_POWER        7
`define CVR_RC_PIN_OE       6
`define CVR_RC_RANGE        5
`define CVR_RC_SOURCE       4
`define CVR_RC_LEVEL_HI     3
`define CVR_RC_LEVEL_LO     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CVR_RST_CTRL        16'h0000
`define CVR_RST_REF         8'h00

`endif

//--- hdl/cvr_sync.sv
// Two-flop synchroniser for one analog comparator output
module cvr_sync (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta;

   // ---------------------------------------------
   // Crossing: the first flop feeds only the second
   // ---------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta   <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end

endmodule : cvr_sync
